// ==== verif/aioc_asserts.sv ====
// port-level assertion checker for the actuator config block
`timescale 1ns/1ps
module aioc_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire aioc_pkg::aioc_parallel_io_t parallel_io,
    input wire aioc_pkg::aioc_motion_t motion,
    input wire logic pc_tool_connect,
    input wire logic [2:0] pc_tool_baud,
    input wire logic rx_cmd_done,
    input wire logic tx_done,
    input wire logic tx_allow,
    input wire logic [12:0] baud_divisor,
    input wire logic pause_req,
    input wire logic limit_over
);
    localparam logic [12:0] DIVS [8] = '{13'h1047, 13'hada, 13'h823, 13'h56d, 13'h412, 13'h209, 13'h15b, 13'hae};
    logic [2:0] tool_b;
    logic rd_take;
    // ==========================================
    // helpers
    // read taken this edge
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    // held tool rate, the port may move on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tool_b <= 3'h0;
        end else if (pc_tool_connect) begin
            tool_b <= pc_tool_baud;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    baud_legal_a: assert property ($past(hresetn, 2) |-> baud_divisor inside {DIVS})
        else $error("baud divisor outside the rate table");
    tool_rate_a: assert property (pc_tool_connect |-> ##[1:2] baud_divisor == DIVS[tool_b])
        else $error("tool rate not applied");
    pause_src_a: assert property (pause_req |-> $past(parallel_io.pause_in))
        else $error("pause raised without pause input");
    limit_home_a: assert property (limit_over |-> $past(motion.home_done))
        else $error("limit flagged before home return");
    reply_cancel_a: assert property (rx_cmd_done |=> !tx_allow)
        else $error("reply window open right after a command");
    reply_end_a: assert property (tx_allow && tx_done && !rx_cmd_done |=> !tx_allow)
        else $error("reply window kept after reply sent");
    unmap_zero_a: assert property (rd_take && (haddr[7:0] > 8'h28 || haddr[7:0] == 8'h24) |=> hrdata == 32'h0)
        else $error("unmapped or control read not zero");
    rdata_hold_a: assert property (!rd_take |=> $stable(hrdata)) else $error("read data moved without a read");
endmodule

bind aioc_top aioc_asserts i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .parallel_io, .motion, .pc_tool_connect, .pc_tool_baud, .rx_cmd_done, .tx_done,
    .tx_allow, .baud_divisor, .pause_req, .limit_over);

// ==== verif/aioc_host_model.sv ====
// host controller model: parallel lines and serial command timing
`timescale 1ns/1ps
module aioc_host_model (
    input wire logic hclk,
    input wire logic tx_allow,
    output aioc_pkg::aioc_parallel_io_t parallel_io,
    output logic rx_cmd_done,
    output logic tx_done
);
    logic open_l = 1'b0;
    aioc_pkg::aioc_parallel_io_t lvl = '0;
    initial begin
        parallel_io = '0;
        rx_cmd_done = 1'b0;
        tx_done = 1'b0;
    end
    // ==========================================
    // parallel lines
    // an open line floats: show it toggling
    always @(posedge hclk) begin
        if (open_l) begin
            parallel_io <= {~parallel_io.pause_in, ~parallel_io.servo_in, lvl.cmd_bits};
        end else begin
            parallel_io <= lvl;
        end
    end
    task drive_lines(input logic p, input logic s, input logic o, input logic [7:0] c);
        @(posedge hclk);
        lvl <= {p, s, c};
        open_l <= o;
    endtask
    // ==========================================
    // serial exchange
    // edges to the reply window, then the reply
    task xfer(input int gap, output int lat);
        @(posedge hclk);
        rx_cmd_done <= 1'b1;
        @(posedge hclk);
        rx_cmd_done <= 1'b0;
        lat = 0;
        do begin
            @(negedge hclk);
            lat++;
        end while (tx_allow !== 1'b1 && lat < 4000);
        repeat (gap) @(posedge hclk);
        @(posedge hclk);
        tx_done <= 1'b1;
        @(posedge hclk);
        tx_done <= 1'b0;
    endtask
endmodule

// ==== verif/aioc_top_bench.sv ====
// self-checking bench for the actuator config block
`timescale 1ns/1ps
module aioc_top_bench;
    localparam int MS = 10;
    localparam logic [12:0] DIVS [8] = '{13'h1047, 13'hada, 13'h823, 13'h56d, 13'h412, 13'h209, 13'h15b, 13'hae};
    localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40};
    localparam logic [31:0] RV [11] = '{32'h0, 32'h4, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0, 32'h7fffff, 32'h800000,
        32'h0, 32'h0};
    localparam int MSV [3] = '{32'h0, 32'h3, 32'hff};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic mode2_strap = 1'b0;
    aioc_pkg::aioc_motion_t motion = '0;
    logic pc_tool_connect = 1'b0;
    logic [2:0] pc_tool_baud = 3'h0;
    aioc_pkg::aioc_parallel_io_t parallel_io;
    logic [31:0] hrdata;
    logic hready, hresp, rx_cmd_done, tx_done, tx_allow;
    logic pause_req, servo_on, cmd_valid, zone_out, positioning_complete, limit_over;
    logic [12:0] baud_divisor;
    logic [3:0] cmd_point;
    logic [31:0] rv;
    int lat;
    int num_errors = 0;
    int comparisons = 0;
    // 40 MHz clock
    always #12.5 hclk = ~hclk;
    aioc_top #(.MS_CYCLES(MS)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready, .hrdata, .hreadyout(hready), .hresp, .mode2_strap, .parallel_io, .motion, .pc_tool_connect,
        .pc_tool_baud, .rx_cmd_done, .tx_done, .tx_allow, .baud_divisor, .pause_req, .servo_on, .cmd_point,
        .cmd_valid, .zone_out, .positioning_complete, .limit_over);
    aioc_host_model i_host (.hclk, .tx_allow, .parallel_io, .rx_cmd_done, .tx_done);
    // ==========================================
    // reporting
    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================
    // bus access
    // bounded wait for hready at a rising edge
    task wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            stop_test;
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        rv = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    // status without the live reply and motion bits
    task stat(input logic [31:0] e);
        ahb(1'b0, 8'h28, 32'h0);
        chk(rv & 32'h0077ff0f, e);
    endtask
    task nap(input int n);
        repeat (n) @(negedge hclk);
    endtask
    task boot;
        wr(8'h24, 32'h1);
        nap(3);
    endtask
    task mot(input logic h, input logic [23:0] m, input logic [23:0] t, input logic [23:0] w,
        input logic [23:0] lo, input logic [23:0] hi);
        @(posedge hclk);
        motion <= {h, m, t, w, lo, hi};
        nap(3);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            rd(RA[i], RV[i]);
        end
        wr(8'h28, 32'hffffffff);
        stat(32'h00400500);
        chk(32'(baud_divisor), 32'h412);
        $display("reset values done");
        i_host.drive_lines(1'b1, 1'b0, 1'b0, 8'h0);
        nap(3);
        chk(32'(pause_req), 32'h1);
        chk(32'(servo_on), 32'h0);
        wr(8'h00, 32'h3);
        nap(2);
        chk(32'(pause_req), 32'h1);
        boot;
        i_host.drive_lines(1'b1, 1'b0, 1'b1, 8'h0);
        for (int i = 0; i < 3; i++) begin
            nap(1);
            chk({pause_req, servo_on}, 32'h1);
        end
        i_host.drive_lines(1'b0, 1'b1, 1'b0, 8'h0);
        wr(8'h00, 32'h0);
        boot;
        $display("input disable done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h04, 32'(i));
            boot;
            chk(32'(baud_divisor), 32'(DIVS[i]));
        end
        @(posedge hclk);
        pc_tool_connect <= 1'b1;
        @(posedge hclk);
        pc_tool_connect <= 1'b0;
        wr(8'h04, 32'h2);
        nap(3);
        chk(32'(baud_divisor), 32'h1047);
        boot;
        chk(32'(baud_divisor), 32'h823);
        $display("baud rates done");
        for (int i = 0; i < 3; i++) begin
            wr(8'h08, 32'(MSV[i]));
            boot;
            i_host.xfer(i * 7, lat);
            chk(32'(lat >= MSV[i] * MS && lat < 4000), 32'h1);
            if (lat >= 4000) stop_test;
            nap(2);
            chk(32'(tx_allow), 32'h0);
        end
        $display("reply delay done");
        i_host.drive_lines(1'b0, 1'b1, 1'b0, 8'h07);
        nap(3);
        chk({cmd_valid, cmd_point}, 32'h17);
        wr(8'h10, 32'h1);
        boot;
        i_host.drive_lines(1'b0, 1'b1, 1'b0, 8'h02);
        nap(3);
        chk({cmd_valid, cmd_point}, 32'h11);
        i_host.drive_lines(1'b0, 1'b1, 1'b0, 8'h03);
        nap(3);
        chk(32'(cmd_valid), 32'h0);
        wr(8'h10, 32'h2);
        boot;
        i_host.drive_lines(1'b0, 1'b1, 1'b0, 8'h0f);
        nap(3);
        chk({cmd_valid, cmd_point}, 32'h1f);
        wr(8'h10, 32'h3);
        boot;
        stat(32'h0022ff00);
        $display("io patterns done");
        wr(8'h0c, 32'h32);
        wr(8'h18, 32'h64);
        wr(8'h14, 32'hc8);
        wr(8'h1c, 32'hc8);
        mot(1'b0, 24'h96, 24'h64, 24'h0, 24'h0, 24'h3e8);
        chk(32'(positioning_complete), 32'h1);
        mot(1'b1, 24'h96, 24'h64, 24'h0, 24'h0, 24'h3e8);
        chk(32'(zone_out), 32'h1);
        mot(1'b1, 24'h96, 24'h64, 24'h0, 24'hc8, 24'h3e8);
        chk(32'(zone_out), 32'h0);
        wr(8'h00, 32'h4);
        boot;
        chk(32'(zone_out), 32'h1);
        mot(1'b1, 24'h95, 24'h64, 24'h0, 24'hc8, 24'h3e8);
        chk({zone_out, positioning_complete}, 32'h0);
        mot(1'b1, 24'h95, 24'h64, 24'h1, 24'hc8, 24'h3e8);
        chk(32'(positioning_complete), 32'h1);
        mot(1'b1, 24'h12c, 24'h64, 24'h1, 24'hc8, 24'h3e8);
        chk(32'(limit_over), 32'h1);
        wr(8'h0c, 32'h96);
        nap(3);
        chk(32'(limit_over), 32'h0);
        wr(8'h0c, 32'hfffff);
        rd(8'h0c, 32'hf423f);
        wr(8'h0c, 32'h32);
        wr(8'h10, 32'h0);
        boot;
        mot(1'b0, 24'h96, 24'h64, 24'h0, 24'h0, 24'h0);
        chk(32'(zone_out), 32'h0);
        mot(1'b1, 24'h96, 24'h64, 24'h0, 24'h0, 24'h0);
        chk(32'(zone_out), 32'h1);
        $display("zones and offset done");
        @(posedge hclk);
        mode2_strap <= 1'b1;
        wr(8'h10, 32'h5);
        boot;
        stat(32'h0025ff0c);
        $display("second mode pattern done");
        stop_test;
    end
endmodule

// ==== verilog/aioc_defs.svh ====
// register offsets, reset values and timing constants for the actuator config block
`ifndef AIOC_DEFS_SVH
`define AIOC_DEFS_SVH
// ==========================================
// register byte offsets
`define AIOC_OFS_FLAGS 8'h00
`define AIOC_OFS_BAUD 8'h04
`define AIOC_OFS_RDLY 8'h08
`define AIOC_OFS_HOFS 8'h0c
`define AIOC_OFS_PAT 8'h10
`define AIOC_OFS_ZHI 8'h14
`define AIOC_OFS_ZLO 8'h18
`define AIOC_OFS_LPOS 8'h1c
`define AIOC_OFS_LNEG 8'h20
`define AIOC_OFS_CTRL 8'h24
`define AIOC_OFS_STAT 8'h28
// ==========================================
// field positions
`define AIOC_FLG_PAUSE_DIS 0
`define AIOC_FLG_SERVO_DIS 1
`define AIOC_FLG_ZONE_REMAP 2
`define AIOC_CTRL_RESTART 0
// ==========================================
// reset values
`define AIOC_RST_FLAGS 3'h0
`define AIOC_RST_BAUD 3'h4
`define AIOC_RST_RDLY 8'h05
`define AIOC_RST_HOFS 20'h00000
`define AIOC_RST_PAT 3'h0
`define AIOC_RST_ZHI 24'h000000
`define AIOC_RST_ZLO 24'h000000
`define AIOC_RST_LPOS 24'h7fffff
`define AIOC_RST_LNEG 24'h800000
`define AIOC_HOFS_MAX 20'hf423f
// ==========================================
// timing
`define AIOC_CLK_HZ 40000000
`define AIOC_CLK_NS 25
`define AIOC_MS_NS 1000000
`define AIOC_MS_CYCLES (`AIOC_MS_NS / `AIOC_CLK_NS)
`define AIOC_PAT_MAX_MODE1 3'h2
`define AIOC_PAT_MAX_MODE2 3'h5
`endif

// ==== verilog/aioc_pkg.sv ====
// types shared by the actuator config block
package aioc_pkg;
    // ==========================================
    // active configuration, frozen between restarts except the pc tool rate
    typedef struct packed {
        logic pause_dis;
        logic servo_dis;
        logic zone_remap;
        logic mode2;
        logic [2:0] pattern;
        logic [2:0] baud;
        logic [7:0] reply_ms;
    } aioc_cfg_t;

    // parallel inputs from the host controller
    typedef struct packed {
        logic pause_in;
        logic servo_in;
        logic [7:0] cmd_bits;
    } aioc_parallel_io_t;

    // motion state reported by the servo core
    typedef struct packed {
        logic home_done;
        logic [23:0] mech_pos;
        logic [23:0] target_pos;
        logic [23:0] width;
        logic [23:0] pz_lo;
        logic [23:0] pz_hi;
    } aioc_motion_t;

    typedef enum logic [1:0] {
        AIOC_RD_IDLE = 2'b00,
        AIOC_RD_WAIT = 2'b01,
        AIOC_RD_READY = 2'b10
    } aioc_rdly_state_t;
endpackage

// ==== verilog/aioc_top.sv ====
// actuator host-interface configuration block with ahb-lite register slave
`timescale 1ns/1ps
`include "aioc_defs.svh"

// Operation
// - pause setting 1 ignores pause input
// - motion allowed with pause line open
// - eight baud rates, default 38400
// - pc tool rate until next restart
// - wait configured ms before reply
// - servo setting 1 forces servo on
// - operation allowed with servo line open
// - home offset 0.00 to 9999.99 mm
// - soft limits referenced to home position
// - io pattern 0 to 5, default 0
// - pattern 0: eight binary points, zone
// - pattern 1: three individual points
// - pattern 2: sixteen binary points, pzone
// - zone output only after home return
// - position zone uses commanded point range
// - remap setting turns pzone into zone
// - complete when remaining within width
module aioc_top #(
    parameter int MS_CYCLES = `AIOC_MS_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mode2_strap,
    input wire aioc_pkg::aioc_parallel_io_t parallel_io,
    input wire aioc_pkg::aioc_motion_t motion,
    input wire logic pc_tool_connect,
    input wire logic [2:0] pc_tool_baud,
    input wire logic rx_cmd_done,
    input wire logic tx_done,
    output logic tx_allow,
    output logic [12:0] baud_divisor,
    output logic pause_req,
    output logic servo_on,
    output logic [3:0] cmd_point,
    output logic cmd_valid,
    output logic zone_out,
    output logic positioning_complete,
    output logic limit_over
);
    // ==========================================
    // stored settings and active copy
    logic [2:0] io_function_flags;
    logic [2:0] serial_baud_select;
    logic [7:0] reply_delay_time;
    logic [19:0] home_offset_distance;
    logic [2:0] io_pattern_select;
    logic [23:0] zone_hi;
    logic [23:0] zone_lo;
    logic [23:0] limit_pos;
    logic [23:0] limit_neg;
    aioc_pkg::aioc_cfg_t cfg;
    logic restart;
    logic boot;
    logic [2:0] next_pattern;
    logic [2:0] pat_max;

    // ==========================================
    // ahb-lite slave
    logic dp_write;
    logic [7:0] dp_addr;
    logic ap_valid;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign ap_valid = hsel & htrans[1] & hready;

    // address phase captured for the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= ap_valid & hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // zero wait state, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign status_word = {8'h00, 1'b0, cfg.baud, 1'b0, cfg.pattern, cfg.reply_ms,
                          tx_allow, zone_out, positioning_complete, limit_over,
                          cfg.mode2, cfg.zone_remap, cfg.servo_dis, cfg.pause_dis};

    // read decode in the address phase so data stands in the data phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `AIOC_OFS_FLAGS: rd_mux = {29'h0, io_function_flags};
            `AIOC_OFS_BAUD: rd_mux = {29'h0, serial_baud_select};
            `AIOC_OFS_RDLY: rd_mux = {24'h0, reply_delay_time};
            `AIOC_OFS_HOFS: rd_mux = {12'h0, home_offset_distance};
            `AIOC_OFS_PAT: rd_mux = {29'h0, io_pattern_select};
            `AIOC_OFS_ZHI: rd_mux = {8'h0, zone_hi};
            `AIOC_OFS_ZLO: rd_mux = {8'h0, zone_lo};
            `AIOC_OFS_LPOS: rd_mux = {8'h0, limit_pos};
            `AIOC_OFS_LNEG: rd_mux = {8'h0, limit_neg};
            `AIOC_OFS_STAT: rd_mux = status_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_valid & ~hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // stored settings, writable any time; flags, baud, delay and pattern apply at restart, offset, zone and limits at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_function_flags <= `AIOC_RST_FLAGS;
            serial_baud_select <= `AIOC_RST_BAUD;
            reply_delay_time <= `AIOC_RST_RDLY;
            home_offset_distance <= `AIOC_RST_HOFS;
            io_pattern_select <= `AIOC_RST_PAT;
            zone_hi <= `AIOC_RST_ZHI;
            zone_lo <= `AIOC_RST_ZLO;
            limit_pos <= `AIOC_RST_LPOS;
            limit_neg <= `AIOC_RST_LNEG;
        end else if (dp_write) begin
            case (dp_addr)
                `AIOC_OFS_FLAGS: io_function_flags <= hwdata[2:0];
                `AIOC_OFS_BAUD: serial_baud_select <= hwdata[2:0];
                `AIOC_OFS_RDLY: reply_delay_time <= hwdata[7:0];
                `AIOC_OFS_HOFS: begin
                    // out of range offsets clamp to 9999.99 mm
                    if (hwdata[19:0] > `AIOC_HOFS_MAX || hwdata[31:20] != 12'h000) begin
                        home_offset_distance <= `AIOC_HOFS_MAX;
                    end else begin
                        home_offset_distance <= hwdata[19:0];
                    end
                end
                `AIOC_OFS_PAT: io_pattern_select <= hwdata[2:0];
                `AIOC_OFS_ZHI: zone_hi <= hwdata[23:0];
                `AIOC_OFS_ZLO: zone_lo <= hwdata[23:0];
                `AIOC_OFS_LPOS: limit_pos <= hwdata[23:0];
                `AIOC_OFS_LNEG: limit_neg <= hwdata[23:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // restart: first cycle after reset release, or software power cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot <= 1'b1;
        end else begin
            boot <= 1'b0;
        end
    end

    assign restart = boot | (dp_write & (dp_addr == `AIOC_OFS_CTRL) & hwdata[`AIOC_CTRL_RESTART]);
    assign pat_max = mode2_strap ? `AIOC_PAT_MAX_MODE2 : `AIOC_PAT_MAX_MODE1;
    // an undefined pattern leaves the running one in place
    assign next_pattern = (io_pattern_select <= pat_max) ? io_pattern_select : cfg.pattern;

    // active copy only moves at restart; pc tool may override the rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= '{pause_dis: 1'b0, servo_dis: 1'b0, zone_remap: 1'b0, mode2: 1'b0,
                     pattern: `AIOC_RST_PAT, baud: `AIOC_RST_BAUD, reply_ms: `AIOC_RST_RDLY};
        end else if (restart) begin
            cfg.pause_dis <= io_function_flags[`AIOC_FLG_PAUSE_DIS];
            cfg.servo_dis <= io_function_flags[`AIOC_FLG_SERVO_DIS];
            cfg.zone_remap <= io_function_flags[`AIOC_FLG_ZONE_REMAP];
            cfg.mode2 <= mode2_strap;
            cfg.pattern <= next_pattern;
            cfg.baud <= serial_baud_select;
            cfg.reply_ms <= reply_delay_time;
        end else if (pc_tool_connect) begin
            cfg.baud <= pc_tool_baud;
        end
    end

    // ==========================================
    // baud divisor for the serial link
    function automatic logic [12:0] aioc_div(input logic [2:0] sel);
        case (sel)
            3'h0: aioc_div = 13'((`AIOC_CLK_HZ + 4800) / 9600);
            3'h1: aioc_div = 13'((`AIOC_CLK_HZ + 7200) / 14400);
            3'h2: aioc_div = 13'((`AIOC_CLK_HZ + 9600) / 19200);
            3'h3: aioc_div = 13'((`AIOC_CLK_HZ + 14400) / 28800);
            3'h4: aioc_div = 13'((`AIOC_CLK_HZ + 19200) / 38400);
            3'h5: aioc_div = 13'((`AIOC_CLK_HZ + 38400) / 76800);
            3'h6: aioc_div = 13'((`AIOC_CLK_HZ + 57600) / 115200);
            default: aioc_div = 13'((`AIOC_CLK_HZ + 115200) / 230400);
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_divisor <= 13'h0000;
        end else begin
            baud_divisor <= aioc_div(cfg.baud);
        end
    end

    // ==========================================
    // reply delay after a complete command
    aioc_pkg::aioc_rdly_state_t rd_state;
    logic [15:0] ms_pre;
    logic [7:0] ms_left;

    // prescaler restarts with each command so the first ms is whole
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_state <= aioc_pkg::AIOC_RD_IDLE;
            ms_pre <= 16'h0000;
            ms_left <= 8'h00;
            tx_allow <= 1'b0;
        end else if (rx_cmd_done) begin
            rd_state <= aioc_pkg::AIOC_RD_WAIT;
            ms_pre <= 16'h0000;
            ms_left <= cfg.reply_ms;
            tx_allow <= 1'b0;
        end else begin
            case (rd_state)
                aioc_pkg::AIOC_RD_IDLE: begin
                    tx_allow <= 1'b0;
                end
                aioc_pkg::AIOC_RD_WAIT: begin
                    if (ms_left == 8'h00) begin
                        rd_state <= aioc_pkg::AIOC_RD_READY;
                        tx_allow <= 1'b1;
                    end else if (ms_pre == 16'(MS_CYCLES - 1)) begin
                        ms_pre <= 16'h0000;
                        ms_left <= ms_left - 8'h01;
                    end else begin
                        ms_pre <= ms_pre + 16'h0001;
                    end
                end
                aioc_pkg::AIOC_RD_READY: begin
                    if (tx_done) begin
                        rd_state <= aioc_pkg::AIOC_RD_IDLE;
                        tx_allow <= 1'b0;
                    end
                end
                default: begin
                    rd_state <= aioc_pkg::AIOC_RD_IDLE;
                    tx_allow <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================
    // pause and servo-on gating
    // a disabled input is never looked at, so an open line is harmless
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_req <= 1'b0;
            servo_on <= 1'b0;
        end else begin
            pause_req <= ~cfg.pause_dis & parallel_io.pause_in;
            servo_on <= cfg.servo_dis | parallel_io.servo_in;
        end
    end

    // ==========================================
    // position command decode
    logic [3:0] dec_point;
    logic dec_valid;

    // mode 2 patterns are decoded elsewhere; here they give no command
    always_comb begin
        dec_point = 4'h0;
        dec_valid = 1'b0;
        if (!cfg.mode2) begin
            case (cfg.pattern)
                3'h0: begin
                    dec_point = {1'b0, parallel_io.cmd_bits[2:0]};
                    dec_valid = 1'b1;
                end
                3'h1: begin
                    // one-hot inputs; two at once is no command
                    case (parallel_io.cmd_bits[2:0])
                        3'b001: begin dec_point = 4'h0; dec_valid = 1'b1; end
                        3'b010: begin dec_point = 4'h1; dec_valid = 1'b1; end
                        3'b100: begin dec_point = 4'h2; dec_valid = 1'b1; end
                        default: dec_valid = 1'b0;
                    endcase
                end
                3'h2: begin
                    dec_point = parallel_io.cmd_bits[3:0];
                    dec_valid = 1'b1;
                end
                default: dec_valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_point <= 4'h0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_point <= dec_point;
            cmd_valid <= dec_valid;
        end
    end

    // ==========================================
    // coordinates, zones, limits, completion
    logic signed [24:0] home_pos;
    logic signed [24:0] remain;
    logic in_zone;
    logic in_pzone;
    logic zone_sel;

    // home sits offset from the mechanical end; limits follow it
    assign home_pos = $signed({motion.mech_pos[23], motion.mech_pos}) -
                      $signed({5'h00, home_offset_distance});
    assign remain = $signed({motion.target_pos[23], motion.target_pos}) - home_pos;
    assign in_zone = (home_pos >= $signed({zone_lo[23], zone_lo})) &&
                     (home_pos <= $signed({zone_hi[23], zone_hi}));
    // range supplied belongs to the commanded point only
    assign in_pzone = cmd_valid && (home_pos >= $signed({motion.pz_lo[23], motion.pz_lo})) &&
                      (home_pos <= $signed({motion.pz_hi[23], motion.pz_hi}));

    // pattern 0 zone, pattern 2 zone or position zone, none otherwise
    always_comb begin
        zone_sel = 1'b0;
        if (!cfg.mode2) begin
            case (cfg.pattern)
                3'h0: zone_sel = in_zone;
                3'h2: zone_sel = cfg.zone_remap ? in_zone : in_pzone;
                default: zone_sel = 1'b0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zone_out <= 1'b0;
            positioning_complete <= 1'b0;
            limit_over <= 1'b0;
        end else begin
            zone_out <= motion.home_done & zone_sel;
            positioning_complete <= (remain <= $signed({1'b0, motion.width})) &&
                                    (remain >= -$signed({1'b0, motion.width}));
            limit_over <= motion.home_done &&
                          ((home_pos > $signed({limit_pos[23], limit_pos})) ||
                           (home_pos < $signed({limit_neg[23], limit_neg})));
        end
    end
endmodule
